// ### logic/bzo_top.sv
// tone output block: register slave, divider and port A pin muxing
`include "bzo_cfg.svh"

module bzo_top #(
  parameter bzo_pkg::bzo_opt_e OPTION = bzo_pkg::BZO_OPT_PAIR
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // state and divider

  bzo_pkg::bzo_state_s s;
  bzo_pkg::bzo_state_s next_s;
  logic tone;
  logic request;
  logic accept;
  logic [31:0] read_mux;
  logic [7:0] pin_out_calc;
  logic [7:0] pin_oe_calc;
  logic gate1;

  bzo_tone_if tif ();

  // overflow pulses and the source bit feed the divider
  assign tif.ovf0 = timer0_overflow;
  assign tif.ovf1 = timer1_overflow;
  assign tif.src_sel = s.tone_source_select;
  assign tone = tif.tone;

  bzo_tone_div u_div (
    .clock(clock),
    .rst(rst),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  // a request is answered one cycle after it appears
  assign request = avs_read | avs_write;
  assign accept = request & ~s.waitrequest;

  // read data for the addressed register, zero when unmapped
  always_comb begin
    read_mux = 32'h0000_0000;
    case (avs_address)
      `BZO_OFF_PORT_DATA: begin
        read_mux[7:0] = s.port_a_data;
      end
      `BZO_OFF_PORT_DIR: begin
        read_mux[7:0] = s.port_a_direction;
      end
      `BZO_OFF_CONTROL: begin
        read_mux[`BZO_CTRL_SRC_BIT] = s.tone_source_select;
      end
      `BZO_OFF_STATUS: begin
        read_mux[7:0] = port_a_in;
        read_mux[`BZO_STAT_TONE_BIT] = tone;
        read_mux[`BZO_STAT_OPT_LSB +: 2] = OPTION;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function of port A

  // line 1 data bit gates the tone on both tone lines
  assign gate1 = s.port_a_data[`BZO_LINE1];

  always_comb begin
    // plain I/O: direction bit low drives the data latch
    pin_out_calc = s.port_a_data;
    pin_oe_calc = ~s.port_a_direction;
    case (OPTION)
      bzo_pkg::BZO_OPT_PAIR: begin
        pin_out_calc[`BZO_LINE1] = gate1 & tone;
        pin_out_calc[`BZO_LINE2] = gate1 & ~tone;
      end
      bzo_pkg::BZO_OPT_SINGLE: begin
        pin_out_calc[`BZO_LINE1] = gate1 & tone;
      end
      default: begin
        pin_out_calc = s.port_a_data;
      end
    endcase
    // input direction wins on every line, both tone lines included
    // line 2 input, line 1 tone
    // line 1 input, line 2 tone
    pin_oe_calc = ~s.port_a_direction;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.waitrequest = 1'h1;
    // first cycle of a request: load answer, drop waitrequest
    if (request && s.waitrequest) begin
      next_s.waitrequest = 1'h0;
      next_s.readdata = read_mux;
    end
    // write lands at the edge where waitrequest is seen low
    if (accept && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        `BZO_OFF_PORT_DATA: begin
          next_s.port_a_data = avs_writedata[7:0];
        end
        `BZO_OFF_PORT_DIR: begin
          next_s.port_a_direction = avs_writedata[7:0];
        end
        `BZO_OFF_CONTROL: begin
          next_s.tone_source_select = avs_writedata[`BZO_CTRL_SRC_BIT];
        end
        default: begin
          next_s.tone_source_select = s.tone_source_select;
        end
      endcase
    end
    // pins are registered so every output comes from a flop
    next_s.pin_out = pin_out_calc;
    next_s.pin_oe = pin_oe_calc;
  end

  // state register; ports start as inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      s.port_a_data <= `BZO_RST_PORT_DATA;
      s.port_a_direction <= `BZO_RST_PORT_DIR;
      s.tone_source_select <= `BZO_RST_SRC_SEL;
      s.pin_out <= 8'h00;
      s.pin_oe <= 8'h00;
      s.waitrequest <= 1'h1;
      s.readdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata = s.readdata;
  assign avs_waitrequest = s.waitrequest;
  assign port_a_out = s.pin_out;
  assign port_a_oe = s.pin_oe;

endmodule

// ### logic/bzo_cfg.svh
// register offsets, field positions and reset values of the tone output block
`ifndef BZO_CFG_SVH
`define BZO_CFG_SVH

// byte offsets on the register bus
`define BZO_OFF_PORT_DATA 8'h00
`define BZO_OFF_PORT_DIR 8'h04
`define BZO_OFF_CONTROL 8'h08
`define BZO_OFF_STATUS 8'h0c

// port line numbers that carry the tone pair
`define BZO_LINE1 1
`define BZO_LINE2 2

// field positions
`define BZO_CTRL_SRC_BIT 0
`define BZO_STAT_TONE_BIT 8
`define BZO_STAT_OPT_LSB 9

// reset values
`define BZO_RST_PORT_DATA 8'h00
`define BZO_RST_PORT_DIR 8'hff
`define BZO_RST_SRC_SEL 1'h0

`endif

// ### logic/bzo_pkg.sv
// types shared by the tone output block
package bzo_pkg;

  // build-time pin assignment of the two shared lines
  typedef enum logic [1:0] {
    BZO_OPT_GPIO = 2'h0,
    BZO_OPT_PAIR = 2'h1,
    BZO_OPT_SINGLE = 2'h2
  } bzo_opt_e;

  // whole state of the top module
  typedef struct packed {
    logic [7:0] port_a_data;
    logic [7:0] port_a_direction;
    logic tone_source_select;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic waitrequest;
    logic [31:0] readdata;
  } bzo_state_s;

  // whole state of the divider
  typedef struct packed {
    logic tone;
  } bzo_div_state_s;

endpackage

// ### logic/bzo_tone_if.sv
// overflow pulses in, tone level out, between top and divider
interface bzo_tone_if;
  logic ovf0;
  logic ovf1;
  logic src_sel;
  logic tone;

  modport top (output ovf0, output ovf1, output src_sel, input tone);
  modport div (input ovf0, input ovf1, input src_sel, output tone);
endinterface

// ### logic/bzo_tone_div.sv
// divide-by-two of the selected timer overflow pulse
module bzo_tone_div (
  input wire logic clock,
  input wire logic rst,
  bzo_tone_if.div tif
);

  bzo_pkg::bzo_div_state_s s;
  bzo_pkg::bzo_div_state_s next_s;
  logic pulse;

  assign pulse = tif.src_sel ? tif.ovf1 : tif.ovf0;

  always_comb begin
    next_s = s;
    if (pulse) begin
      next_s.tone = ~s.tone;
    end
  end

  // state register, cleared by chip reset
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tif.tone = s.tone;

endmodule

// ### testbench/bzo_checker.sv
// port assertions of the tone block
module bzo_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe
);
  logic d1;
  logic src;
  logic [1:0] dr;
  wire logic acc = avs_write && !avs_waitrequest;
  wire logic sp = src ? timer1_overflow : timer0_overflow;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // shadow of the bits the pins hang on
  always_ff @(posedge clock) begin
    if (rst) begin
      d1 <= 1'b0;
      src <= 1'b0;
      dr <= 2'h3;
    end else if (acc && avs_address == 8'h00) begin
      d1 <= avs_writedata[1];
    end else if (acc && avs_address == 8'h04) begin
      dr <= avs_writedata[2:1];
    end else if (acc && avs_address == 8'h08) begin
      src <= avs_writedata[0];
    end
  end
  wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  hi_a: assert property (!avs_waitrequest |-> avs_readdata[31:11] == 21'h0) else $error("upper bits set");
  dir_wins_a: assert property (port_a_oe[2:1] == ~$past(dr)) else $error("direction ignored");
  gate_a: assert property (!$past(d1) |-> !(port_a_out[1] && port_a_oe[1]) && !(port_a_out[2] && port_a_oe[2]))
    else $error("gated tone leaks");
  pair_a: assert property ($past(d1) && port_a_oe[2:1] == 2'h3 |-> port_a_out[1] != port_a_out[2])
    else $error("pair not inverse");
  tone_a: assert property (sp && d1 ##1 d1 |=> port_a_out[1] != $past(port_a_out[1]))
    else $error("tone not toggled");
  reset_a: assert property (disable iff (1'b0) rst |=> avs_waitrequest && port_a_oe == 8'h00 && port_a_out == 8'h00)
    else $error("reset state wrong");
endmodule
bind bzo_top bzo_checker chk (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
  .port_a_out(port_a_out), .port_a_oe(port_a_oe));

// ### testbench/bzo_piezo.sv
// buzzer load with pull-ups on port A
module bzo_piezo (
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  output logic [7:0] pin
);
  // released lines float up
  assign pin = (port_a_out & port_a_oe) | ~port_a_oe;
endmodule

// ### testbench/bzo_bench.sv
// self-checking bench of the tone block
module bzo_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wt, t0 = 1'b0, t1 = 1'b0;
  logic [7:0] adr = 8'h00, pin, po, oe;
  logic [31:0] wd = 32'h0, rdat, q;
  int err_count = 0, cmp_count = 0, cyc = 0;
  bzo_top uut (.clock(clock), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wt), .timer0_overflow(t0),
    .timer1_overflow(t1), .port_a_in(pin), .port_a_out(po), .port_a_oe(oe));
  bzo_piezo load (.port_a_out(po), .port_a_oe(oe), .pin(pin));
  initial forever #50 clock = ~clock;
  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pin_chk(logic [1:0] eo, logic [1:0] ev);
    repeat (2) @(posedge clock);
    chk({30'h0, oe[2:1]}, {30'h0, eo});
    chk({30'h0, po[2:1] & oe[2:1]}, {30'h0, ev});
  endtask
  // one bus access held until waitrequest is seen low
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do @(posedge clock); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pulse(logic s);
    @(posedge clock);
    t0 <= !s;
    t1 <= s;
    @(posedge clock);
    t0 <= 1'b0;
    t1 <= 1'b0;
  endtask
  task automatic s_reset;
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'hff);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h2ff);
    bus(1'b1, 8'h10, 32'hff);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic s_pair;
    bus(1'b1, 8'h04, 32'hf9);
    pin_chk(2'h3, 2'h0);
    bus(1'b1, 8'h00, 32'h02);
    pin_chk(2'h3, 2'h2);
    pulse(1'b0);
    pin_chk(2'h3, 2'h1);
    bus(1'b0, 8'h0c, 32'h0);
    chk({31'h0, q[8]}, 32'h1);
    pulse(1'b1);
    pin_chk(2'h3, 2'h1);
    bus(1'b1, 8'h08, 32'h1);
    pulse(1'b1);
    pin_chk(2'h3, 2'h2);
    bus(1'b1, 8'h00, 32'h04);
    pin_chk(2'h3, 2'h0);
  endtask
  task automatic s_dir;
    bus(1'b1, 8'h00, 32'h02);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h04, {29'h0, i[1:0], 1'b0});
      pin_chk(~i[1:0], 2'h2 & ~i[1:0]);
      bus(1'b0, 8'h0c, 32'h0);
      chk({30'h0, q[2:1]}, {30'h0, 1'b1, i[0]});
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    s_reset;
    s_pair;
    s_dir;
    end_sim;
  end
endmodule
